// [logic/srea_top.sv]
/*
  srea_top: serial bus slave that decodes command bytes into register, array,
  block and erase operations.  Assumes an open-drain data line resolved outside,
  a bus clock far slower than i_clk, and no clock stretching.
*/
// Behaviour
// - registers at 00h-7Fh, array at 8000h-813Fh, chosen by command byte
// - command A2h plus page location starts an erase, no enable bit
// - array is 16 pages of 32 bytes; default page starts at 8100h
// - erase page from high byte and top three low bits; low five ignored
// - erase lasts about 20 ms; array access meanwhile is not acknowledged
// - send byte: start, address write, command, each acknowledged, stop
// - send byte with register address loads the pointer
// - repeated start after last acknowledge continues without stop
// - write byte/word: command then one or two data bytes
// - command 00h-7Fh with one data byte writes that register
// - command 80h with one data byte loads pointer 80xxh
// - 80h/81h, low address, data writes array byte if control bit set
// - block write: A0h, count up to 32, data bytes, stop
// - array block write stays inside its 32-byte page
// - receive byte: address read, one byte, master not-acknowledge, stop
// - receive byte returns the most recently selected location
// - block read: set location, A1h, repeated start, multi-byte read
// - extension bit resets low, takes effect only after reset reload; here reset also erases the array, so the reload always gives 0
// - address 1010 plus pin and extension bit, six addresses; here the extension bit stays 0, so only three answer
// - block read returns count byte, always 20h (32), then bytes until the master does not acknowledge
// - unused or out-of-range reads give zero; only block transfers advance
`timescale 1ns/100ps
module srea_top #(
  parameter int P_ERASE_CYC = srea_pkg::ERASE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [1:0] i_addr_select_pin,
  output logic o_sda_out,
  output logic o_sda_oe,
  output logic o_nv_busy
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RXB = 3'b001,
    ST_ACK = 3'b010,
    ST_TXB = 3'b011,
    ST_MACK = 3'b100
  } srea_state_e;

  srea_state_e state_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q, tx_q, cmd_q, hi_q;
  logic [2:0] k_q;
  logic [15:0] ptr_q;
  logic [5:0] remain_q;
  logic rw_q, blkrd_q, cnt_pend_q, stop_adv_q;
  logic scl_rise, scl_fall, start, stop, sda;
  logic [1:0] pin_sel;
  logic [7:0] rd_data, txbyte;
  logic busy, ext, match, nvop, ack, byte_done, take, adv, wr, erase_go, cmd_nv;
  logic [6:0] own_addr;

  // ==========================================================
  // pin sampling and storage
  srea_bus_rx u_rx (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_addr_select_pin(i_addr_select_pin),
    .o_scl_rise(scl_rise),
    .o_scl_fall(scl_fall),
    .o_start(start),
    .o_stop(stop),
    .o_sda(sda),
    .o_pin_sel(pin_sel)
  );

  srea_store #(.P_ERASE_CYC(P_ERASE_CYC)) u_store (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(wr),
    .i_addr(ptr_q),
    .i_wr_data(shift_q),
    .i_erase(erase_go),
    .i_erase_page({hi_q[0], shift_q[7:5]}),
    .o_rd_data(rd_data),
    .o_busy(busy),
    .o_ext(ext)
  );

  // ==========================================================
  // byte decode
  assign own_addr = {srea_pkg::DEV_ADDR_HI, pin_sel == srea_pkg::PIN_NC, ext, pin_sel == srea_pkg::PIN_VDD};
  assign match = (shift_q[7:1] == own_addr);
  assign cmd_nv = (cmd_q == srea_pkg::CMD_NV_USER) || (cmd_q == srea_pkg::CMD_NV_CFG) ||
                  (cmd_q == srea_pkg::CMD_ERASE);
  // any array touch while erasing is refused
  always_comb
  begin
    unique case (k_q)
      3'h0: nvop = shift_q[0] & ptr_q[15];
      3'h1: nvop = (shift_q == srea_pkg::CMD_NV_USER) || (shift_q == srea_pkg::CMD_NV_CFG) ||
                   (shift_q == srea_pkg::CMD_ERASE);
      default: nvop = cmd_nv || ((cmd_q == srea_pkg::CMD_BLK_WR) && ptr_q[15]);
    endcase
  end
  assign ack = ((k_q != 3'h0) || match) && !(busy && nvop);
  assign byte_done = (state_q == ST_RXB) && scl_fall && (bitcnt_q == 4'h8);
  assign take = byte_done && ack;
  assign txbyte = cnt_pend_q ? {2'b00, srea_pkg::BLK_MAX} : (stop_adv_q ? 8'h00 : rd_data);

  // writes: register byte, single array byte, or block data
  always_comb
  begin
    wr = 1'b0;
    adv = 1'b0;
    // a register write lands on the first data byte, so a stop right after it is enough
    if (take && (k_q == 3'h2) && (cmd_q <= srea_pkg::RAM_LAST))
      wr = 1'b1;
    if (take && (k_q == 3'h3) && ((cmd_q == srea_pkg::CMD_NV_USER) || (cmd_q == srea_pkg::CMD_NV_CFG)))
      wr = 1'b1;
    if (take && (k_q >= 3'h3) && (cmd_q == srea_pkg::CMD_BLK_WR) && (remain_q != 6'h00) && !stop_adv_q)
    begin
      wr = 1'b1;
      adv = 1'b1;
    end
    if ((state_q == ST_MACK) && scl_rise && !sda && blkrd_q && !cnt_pend_q)
      adv = 1'b1;
  end
  assign erase_go = take && (k_q == 3'h3) && (cmd_q == srea_pkg::CMD_ERASE) &&
                    (hi_q[7:1] == srea_pkg::NV_HI_TAG) && !busy;

  // ==========================================================
  // bit-level state machine
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_q <= ST_IDLE;
      bitcnt_q <= 4'h0;
      o_sda_oe <= 1'b0;
    end
    else if (stop)
    begin
      state_q <= ST_IDLE;
      o_sda_oe <= 1'b0;
    end
    else if (start)
    begin
      state_q <= ST_RXB;
      bitcnt_q <= 4'h0;
      o_sda_oe <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_IDLE: ;
        ST_RXB:
          if (scl_rise)
            bitcnt_q <= bitcnt_q + 4'h1;
          else if (byte_done)
          begin
            o_sda_oe <= ack;
            state_q <= ack ? ST_ACK : ST_IDLE;
          end
        ST_ACK:
          if (scl_fall)
          begin
            // a read address hands the line straight to the first data bit
            if (rw_q && (k_q == 3'h1))
            begin
              state_q <= ST_TXB;
              o_sda_oe <= ~txbyte[7];
              bitcnt_q <= 4'h1;
            end
            else
            begin
              state_q <= ST_RXB;
              o_sda_oe <= 1'b0;
              bitcnt_q <= 4'h0;
            end
          end
        ST_TXB:
          if (scl_fall)
          begin
            if (bitcnt_q == 4'h8)
            begin
              o_sda_oe <= 1'b0;
              state_q <= ST_MACK;
            end
            else
            begin
              o_sda_oe <= ~tx_q[6];
              bitcnt_q <= bitcnt_q + 4'h1;
            end
          end
        ST_MACK:
          if (scl_rise && sda)
            state_q <= ST_IDLE;
          else if (scl_fall)
          begin
            state_q <= ST_TXB;
            o_sda_oe <= ~txbyte[7];
            bitcnt_q <= 4'h1;
          end
      endcase
    end
  end

  // receive shifter and transmit shifter
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      shift_q <= 8'h00;
      tx_q <= 8'h00;
    end
    else
    begin
      if ((state_q == ST_RXB) && scl_rise)
        shift_q <= {shift_q[6:0], sda};
      if (((state_q == ST_ACK) || (state_q == ST_MACK)) && scl_fall)
        tx_q <= txbyte;
      else if ((state_q == ST_TXB) && scl_fall)
        tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // ==========================================================
  // transaction bookkeeping: byte index, command, direction, modes
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      k_q <= 3'h0;
      cmd_q <= 8'h00;
      hi_q <= 8'h00;
      rw_q <= 1'b0;
      blkrd_q <= 1'b0;
      cnt_pend_q <= 1'b0;
      remain_q <= 6'h00;
    end
    else if (stop)
    begin
      blkrd_q <= 1'b0;
      cnt_pend_q <= 1'b0;
    end
    else if (start)
      k_q <= 3'h0;
    else
    begin
      if (take)
      begin
        k_q <= (k_q == 3'h4) ? 3'h4 : k_q + 3'h1;
        if (k_q == 3'h0)
          rw_q <= shift_q[0];
        if (k_q == 3'h1)
          cmd_q <= shift_q;
        if ((k_q == 3'h1) && (shift_q == srea_pkg::CMD_BLK_RD))
        begin
          blkrd_q <= 1'b1;
          cnt_pend_q <= 1'b1;
        end
        if ((k_q == 3'h2) && (cmd_q == srea_pkg::CMD_BLK_WR))
          remain_q <= (shift_q > 8'(srea_pkg::BLK_MAX)) ? srea_pkg::BLK_MAX : shift_q[5:0];
        else if (wr && (cmd_q == srea_pkg::CMD_BLK_WR))
          remain_q <= remain_q - 6'h01;
        if ((k_q == 3'h2) && (cmd_q == srea_pkg::CMD_ERASE))
          hi_q <= shift_q;
      end
      if ((state_q == ST_MACK) && scl_rise && !sda)
        cnt_pend_q <= 1'b0;
    end
  end

  // pointer: set by send byte or word, moved only by block transfers
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      ptr_q <= 16'h0000;
      stop_adv_q <= 1'b0;
    end
    else if (take && (k_q == 3'h1) && (shift_q <= srea_pkg::RAM_LAST))
    begin
      ptr_q <= {8'h00, shift_q};
      stop_adv_q <= 1'b0;
    end
    else if (take && (k_q == 3'h2) && ((cmd_q == srea_pkg::CMD_NV_USER) || (cmd_q == srea_pkg::CMD_NV_CFG)))
    begin
      ptr_q <= {cmd_q, shift_q};
      stop_adv_q <= 1'b0;
    end
    else if (adv)
    begin
      // array pointer parks at page end instead of carrying into the next page
      if (ptr_q[15] && (ptr_q[4:0] == srea_pkg::PAGE_END))
        stop_adv_q <= 1'b1;
      else if (ptr_q[15] || !ptr_q[7])
        ptr_q <= ptr_q + 16'h0001;
    end
  end

  // data line is only ever pulled low
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_sda_out <= 1'b0;
    else
      o_sda_out <= 1'b0;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
      o_nv_busy <= 1'b0;
    else
      o_nv_busy <= busy;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_addr_byte;
    byte_done && (k_q == 3'h0);
  endsequence
  sequence s_read_enter;
    (state_q == ST_ACK) && scl_fall && rw_q && (k_q == 3'h1);
  endsequence

  property p_addr_nack;
    s_addr_byte and !match |=> !o_sda_oe && (state_q == ST_IDLE);
  endproperty
  a_addr_nack: assert property (p_addr_nack) else $error("foreign address acknowledged");
  property p_busy_nack;
    byte_done && (k_q == 3'h1) && busy && (shift_q == srea_pkg::CMD_ERASE) |=> !o_sda_oe;
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("erase command taken while busy");
  property p_erase_busy;
    erase_go |=> ##1 o_nv_busy [*4];
  endproperty
  a_erase_busy: assert property (p_erase_busy) else $error("busy not raised by erase");
  property p_send_ptr;
    take && (k_q == 3'h1) && (shift_q <= srea_pkg::RAM_LAST) |=> ptr_q == {8'h00, $past(shift_q)};
  endproperty
  a_send_ptr: assert property (p_send_ptr) else $error("pointer not loaded by send byte");
  property p_nv_ptr;
    take && (k_q == 3'h2) && (cmd_q == srea_pkg::CMD_NV_USER) |=> ptr_q == {8'h80, $past(shift_q)};
  endproperty
  a_nv_ptr: assert property (p_nv_ptr) else $error("array pointer not loaded");
  property p_single_hold;
    (state_q == ST_MACK) && scl_rise && !blkrd_q |=> $stable(ptr_q);
  endproperty
  a_single_hold: assert property (p_single_hold) else $error("pointer moved on single read");
  property p_page_stay;
    adv && ptr_q[15] |=> ptr_q[15:5] == $past(ptr_q[15:5]);
  endproperty
  a_page_stay: assert property (p_page_stay) else $error("block crossed a page");
  property p_stop_idle;
    stop |=> (state_q == ST_IDLE) && !o_sda_oe && !blkrd_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not release the bus");
  property p_restart;
    start && !stop |=> (state_q == ST_RXB) && (k_q == 3'h0) && $stable(ptr_q);
  endproperty
  a_restart: assert property (p_restart) else $error("repeated start lost context");
  property p_first_bit;
    s_read_enter |=> (state_q == ST_TXB) && (o_sda_oe == ~tx_q[7]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first read bit wrong");
  property p_count_byte;
    s_read_enter and cnt_pend_q |=> tx_q == {2'b00, srea_pkg::BLK_MAX};
  endproperty
  a_count_byte: assert property (p_count_byte) else $error("block count byte wrong");
endmodule : srea_top

// [logic/srea_pkg.sv]
/*
  srea_pkg: constants shared by the serial slave front end, its pin sampler and its storage.
  Assumes a single 250 MHz system clock and a synchronous active-low reset.
*/
package srea_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int ERASE_MS = 20;
  localparam int ERASE_CYC = ERASE_MS * CLK_MHZ * 1000;
  localparam int ERASE_CNT_W = 23;
  // ==========================================================
  // slave address and pin codes
  localparam logic [3:0] DEV_ADDR_HI = 4'ha;
  localparam logic [1:0] PIN_GND = 2'h0;
  localparam logic [1:0] PIN_VDD = 2'h1;
  localparam logic [1:0] PIN_NC = 2'h2;
  // ==========================================================
  // command codes and address map
  localparam logic [7:0] RAM_LAST = 8'h7f;
  localparam logic [7:0] CMD_NV_USER = 8'h80;
  localparam logic [7:0] CMD_NV_CFG = 8'h81;
  localparam logic [7:0] CMD_BLK_WR = 8'ha0;
  localparam logic [7:0] CMD_BLK_RD = 8'ha1;
  localparam logic [7:0] CMD_ERASE = 8'ha2;
  localparam logic [15:0] NV_LAST = 16'h813f;
  localparam logic [6:0] NV_HI_TAG = 7'h40;
  localparam logic [5:0] BLK_MAX = 6'h20;
  localparam logic [4:0] PAGE_END = 5'h1f;
  // ==========================================================
  // storage geometry and reset values
  localparam int PAGES = 16;
  localparam int PAGE_BYTES = 32;
  localparam int RAM_BYTES = 128;
  localparam int NV_BYTES = PAGES * PAGE_BYTES;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] RAM_RST = 8'h00;
  localparam logic [6:0] NV_CTRL_REG = 7'h03;
  localparam int NV_WE_BIT = 1;
  localparam logic [8:0] CFG4_NV_IDX = 9'h104;
  localparam int EXT_BIT = 1;
endpackage : srea_pkg

// [logic/srea_bus_rx.sv]
/*
  srea_bus_rx: synchronises the serial clock, serial data and address-select pin,
  and marks clock edges, start and stop.  Assumes the bus runs far slower than i_clk.
*/
`timescale 1ns/100ps
module srea_bus_rx (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [1:0] i_addr_select_pin,
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_start,
  output logic o_stop,
  output logic o_sda,
  output logic [1:0] o_pin_sel
);
  logic scl_m_q, scl_s_q, scl_d_q;
  logic sda_m_q, sda_s_q, sda_d_q;
  logic [1:0] pin_m_q, pin_s_q;

  // ==========================================================
  // two-stage synchronisers; only the second stage feeds logic
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
      pin_m_q <= srea_pkg::PIN_GND;
      pin_s_q <= srea_pkg::PIN_GND;
    end
    else
    begin
      scl_m_q <= i_scl;
      scl_s_q <= scl_m_q;
      sda_m_q <= i_sda;
      sda_s_q <= sda_m_q;
      pin_m_q <= i_addr_select_pin;
      pin_s_q <= pin_m_q;
    end
  end

  // delayed copy for edge finding
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end
    else
    begin
      scl_d_q <= scl_s_q;
      sda_d_q <= sda_s_q;
    end
  end

  // data moving while the clock stays high frames a transfer
  assign o_scl_rise = scl_s_q & ~scl_d_q;
  assign o_scl_fall = ~scl_s_q & scl_d_q;
  assign o_start = scl_s_q & scl_d_q & sda_d_q & ~sda_s_q;
  assign o_stop = scl_s_q & scl_d_q & ~sda_d_q & sda_s_q;
  assign o_sda = sda_s_q;
  assign o_pin_sel = pin_s_q;
endmodule : srea_bus_rx

// [logic/srea_store.sv]
/*
  srea_store: volatile register bytes, paged nonvolatile array with erase timer,
  and the address-extension bit loaded from the default page after reset.
  Assumes the caller never starts an erase while busy.
*/
`timescale 1ns/100ps
module srea_store #(
  parameter int P_ERASE_CYC = srea_pkg::ERASE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_erase,
  input wire logic [3:0] i_erase_page,
  output logic [7:0] o_rd_data,
  output logic o_busy,
  output logic o_ext
);
  logic [7:0] ram_q [srea_pkg::RAM_BYTES];
  logic [7:0] nv_q [srea_pkg::NV_BYTES];
  logic [srea_pkg::ERASE_CNT_W-1:0] cnt_q;
  logic load_q;
  logic ram_ok, nv_ok, nv_we;

  // ==========================================================
  // address decode: ram below 80h, array up to its last byte
  assign ram_ok = (i_addr[15:7] == 9'h000);
  assign nv_ok = (i_addr[15:9] == srea_pkg::NV_HI_TAG) && (i_addr <= srea_pkg::NV_LAST);
  assign nv_we = i_wr & nv_ok & ram_q[srea_pkg::NV_CTRL_REG][srea_pkg::NV_WE_BIT];
  // out of range reads as zero
  assign o_rd_data = ram_ok ? ram_q[i_addr[6:0]] : (nv_ok ? nv_q[i_addr[8:0]] : 8'h00);

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      for (int i = 0; i < srea_pkg::RAM_BYTES; i++)
        ram_q[i] <= srea_pkg::RAM_RST;
    end
    else if (i_wr && ram_ok)
      ram_q[i_addr[6:0]] <= i_wr_data;
  end

  // ==========================================================
  // array bytes: erase sets a whole page, writes only clear bits
  genvar g;
  generate
    for (g = 0; g < srea_pkg::NV_BYTES; g++)
    begin : g_nv
      localparam logic [8:0] IDX = 9'(g);
      always_ff @(posedge i_clk)
      begin
        if (!i_rst_n)
          nv_q[g] <= srea_pkg::ERASED;
        else if (i_erase && (IDX[8:5] == i_erase_page))
          nv_q[g] <= srea_pkg::ERASED;
        else if (nv_we && (i_addr[8:0] == IDX))
          nv_q[g] <= nv_q[g] & i_wr_data;
      end
    end
  endgenerate

  // ==========================================================
  // erase timer holds busy for the whole page erase
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_busy <= 1'b0;
      cnt_q <= '0;
    end
    else if (i_erase)
    begin
      o_busy <= 1'b1;
      cnt_q <= srea_pkg::ERASE_CNT_W'(P_ERASE_CYC - 1);
    end
    else if (o_busy)
    begin
      if (cnt_q == '0)
        o_busy <= 1'b0;
      else
        cnt_q <= cnt_q - 1'b1;
    end
  end

  // extension bit is taken once after reset, from the array that reset has just erased, so it always loads 0
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      o_ext <= 1'b0;
      load_q <= 1'b1;
    end
    else if (load_q)
    begin
      load_q <= 1'b0;
      o_ext <= (nv_q[srea_pkg::CFG4_NV_IDX] != srea_pkg::ERASED) &&
               nv_q[srea_pkg::CFG4_NV_IDX][srea_pkg::EXT_BIT];
    end
  end
endmodule : srea_store

// [tb/srea_master.sv]
/*
  srea_master: behavioural bus master driving clock and data for the slave bench.
  Assumes a 250 MHz i_clk, a 12-cycle (48 ns) bus clock and a pulled-up data wire.
*/
`timescale 1ns/100ps
module srea_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  // ==========================================
  // idle: clock stands high, data released to the pull-up
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick

  // start or repeated start: data falls while the clock is high
  task automatic start();
    o_scl <= 1'b0;
    tick(3);
    o_sda <= 1'b1;
    tick(3);
    o_scl <= 1'b1;
    tick(6);
    o_sda <= 1'b0;
    tick(6);
  endtask : start

  // stop: data rises while the clock is high, then the bus rests
  task automatic stop();
    o_scl <= 1'b0;
    tick(3);
    o_sda <= 1'b0;
    tick(3);
    o_scl <= 1'b1;
    tick(6);
    o_sda <= 1'b1;
    tick(6);
  endtask : stop

  // data moves only mid-low phase, sampled mid-high phase
  task automatic bit_io(input logic b, output logic s);
    o_scl <= 1'b0;
    tick(3);
    o_sda <= b;
    tick(3);
    o_scl <= 1'b1;
    tick(3);
    s = i_sda;
    tick(3);
  endtask : bit_io

  // byte MSB first then ninth bit; a_in high releases data for the slave
  task automatic xb(input logic [7:0] d, input logic a_in, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], q[i]);
    bit_io(a_in, a);
  endtask : xb
endmodule : srea_master

// [tb/srea_top_tb.sv]
/*
  srea_top_tb: self-checking bench for the serial slave front end.
  Assumes the master model owns clock and data; the data wire has a pull-up.
*/
`timescale 1ns/100ps
module srea_top_tb;
  localparam int ERASE_T = 2000;
  // per-byte programming pause, scaled down like the erase time
  localparam int PROG_T = 30;
  logic clk;
  logic rst_n;
  logic [1:0] pin;
  logic scl;
  logic sda_m;
  logic sda;
  logic sda_out;
  logic sda_oe;
  logic busy;
  logic [6:0] sa;
  logic [7:0] q;
  logic a;
  int fails;
  int checks;
  // pin code, register address, data
  logic [17:0] rows [3] = '{{2'h0, 8'h00, 8'h5a}, {2'h1, 8'h7f, 8'ha5}, {2'h2, 8'h3c, 8'h01}};

  // ==========================================
  // clock; wire is low when either party pulls it
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  assign sda = sda_m & ~sda_oe;

  srea_top #(.P_ERASE_CYC(ERASE_T)) srea_top_inst (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda),
    .i_addr_select_pin(pin), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_nv_busy(busy));
  srea_master srea_master_inst (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(sda_m));

  // ==========================================
  // compare and report
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done

  // ==========================================
  // transfers built from master bytes; ack bit 0 means acknowledged
  task automatic wb(input logic [7:0] d, input logic nak);
    srea_master_inst.xb(d, 1'b1, q, a);
    chk({7'h0, a}, {7'h0, nak}, "ack");
  endtask : wb

  task automatic rb(input logic [7:0] exp, input logic last, input string what);
    srea_master_inst.xb(8'hff, last, q, a);
    chk(q, exp, what);
  endtask : rb

  task automatic go(input logic rd);
    srea_master_inst.start();
    wb({sa, rd}, 1'b0);
  endtask : go

  task automatic sbyte(input logic [7:0] c);
    go(1'b0);
    wb(c, 1'b0);
    srea_master_inst.stop();
  endtask : sbyte

  task automatic wr2(input logic [7:0] c, input logic [7:0] d);
    go(1'b0);
    wb(c, 1'b0);
    wb(d, 1'b0);
    srea_master_inst.stop();
  endtask : wr2

  task automatic wr3(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] d);
    go(1'b0);
    wb(c, 1'b0);
    wb(lo, 1'b0);
    wb(d, 1'b0);
    srea_master_inst.stop();
  endtask : wr3

  // set the 80xxh pointer then read one byte after a repeated start
  task automatic nvrd(input logic [7:0] lo, input logic [7:0] exp, input string what);
    go(1'b0);
    wb(srea_pkg::CMD_NV_USER, 1'b0);
    wb(lo, 1'b0);
    go(1'b1);
    rb(exp, 1'b1, what);
    srea_master_inst.stop();
  endtask : nvrd

  // block write of n bytes taken from the top of d
  task automatic bw(input int n, input logic [31:0] d);
    go(1'b0);
    wb(srea_pkg::CMD_BLK_WR, 1'b0);
    wb(n[7:0], 1'b0);
    for (int i = 0; i < n; i++)
    begin
      // clock held high before each data byte, so the last data byte gets no programming time before the stop
      srea_master_inst.tick(PROG_T);
      wb(d[31-8*i -: 8], 1'b0);
    end
    srea_master_inst.stop();
  endtask : bw

  // block read: command, repeated start, count byte, then n data bytes
  task automatic brd(input int n, input logic [31:0] d);
    go(1'b0);
    wb(srea_pkg::CMD_BLK_RD, 1'b0);
    go(1'b1);
    rb({2'h0, srea_pkg::BLK_MAX}, 1'b0, "count byte");
    for (int i = 0; i < n; i++)
      rb(d[31-8*i -: 8], i == n - 1, "block data");
    srea_master_inst.stop();
  endtask : brd

  // ==========================================
  // main sequence
  initial
  begin
    fails = 0;
    checks = 0;
    rst_n <= 1'b0;
    pin <= srea_pkg::PIN_GND;
    sa = 7'h50;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({6'h0, sda_oe, busy}, 8'h00, "reset outputs");
    chk({7'h0, sda_out}, 8'h00, "drive value");
    // each row: pin code, wrong address refused, register write and readback
    foreach (rows[i])
    begin
      pin <= rows[i][17:16];
      repeat (8) @(posedge clk);
      sa = {srea_pkg::DEV_ADDR_HI, rows[i][17:16] == srea_pkg::PIN_NC, 1'b0, rows[i][17:16] == srea_pkg::PIN_VDD};
      srea_master_inst.start();
      wb({sa ^ 7'h01, 1'b0}, 1'b1);
      srea_master_inst.stop();
      wr2(rows[i][15:8], rows[i][7:0]);
      go(1'b0);
      wb(rows[i][15:8], 1'b0);
      go(1'b1);
      rb(rows[i][7:0], 1'b1, "register");
      srea_master_inst.stop();
    end
    // array byte write with the enable bit set, then pointer readback
    wr2(8'h03, 8'h02);
    wr3(srea_pkg::CMD_NV_USER, 8'h10, 8'h3c);
    nvrd(8'h10, 8'h3c, "array byte");
    // configuration half: last array byte, then one past the end reads zero
    wr3(srea_pkg::CMD_NV_CFG, 8'h3f, 8'h5a);
    go(1'b0);
    wb(srea_pkg::CMD_NV_CFG, 1'b0);
    wb(8'h3f, 1'b0);
    go(1'b1);
    rb(8'h5a, 1'b0, "config byte");
    rb(8'h5a, 1'b1, "config again");
    srea_master_inst.stop();
    wr2(srea_pkg::CMD_NV_CFG, 8'h40);
    go(1'b1);
    rb(8'h00, 1'b1, "beyond array");
    srea_master_inst.stop();
    // register block write, single reads do not advance, block read does
    sbyte(8'h20);
    bw(3, 32'h11223300);
    sbyte(8'h20);
    go(1'b1);
    rb(8'h11, 1'b0, "single read");
    rb(8'h11, 1'b1, "no advance");
    srea_master_inst.stop();
    sbyte(8'h20);
    brd(3, 32'h11223300);
    // array block write stops at the page end
    wr2(srea_pkg::CMD_NV_USER, 8'h1e);
    bw(3, 32'h0ff05500);
    nvrd(8'h1f, 8'hf0, "page end");
    nvrd(8'h20, 8'hff, "next page");
    // erase page 0 by a low byte with the low five bits set
    wr3(srea_pkg::CMD_ERASE, 8'h80, 8'h1f);
    chk({7'h0, busy}, 8'h01, "busy");
    go(1'b0);
    wb(srea_pkg::CMD_NV_USER, 1'b1);
    srea_master_inst.stop();
    wr2(8'h05, 8'h77);
    for (int n = 0; n < 3000 && busy === 1'b1; n++)
      @(posedge clk);
    chk({7'h0, busy}, 8'h00, "erase end");
    // a hung erase skips the readback and goes straight to the report
    if (busy === 1'b0)
    begin
      nvrd(8'h10, 8'hff, "erased");
      nvrd(8'h1f, 8'hff, "erased end");
    end
    test_done();
  end
endmodule : srea_top_tb
